/* hw/step_sequence_flow_engine.sv */
// Flow-control engine for stored step sequences
// Summary of operation
// RQ1: Define stores loop-open with count at step
// RQ2: Steps between open and close repeat count times
// RQ3: Loop count is a 16-bit value
// RQ4: Up to ten nested active loops
// RQ5: Open and close may sit in different sequences
// RQ6: Host should keep pairs in one sequence
// RQ7: Host places close after its open
// RQ8: Close decrements count, returns to open
// RQ9: Halt ends run, output state held
// RQ10: Halt accepted at steps 1 to 21
// RQ11: Default allocation preloads halt at step 21
// RQ12: Step 21 halt may become return or jump
// RQ13: Jump goes to step 1 of target
// RQ14: Jump accepted at steps 1 to 21
// RQ15: Pause suspends until host resumes
// RQ16: Pause accepted only at steps 1 to 20
// RQ17: Query returns stored type and parameter
// RQ18: Delete-selected erases sequence everywhere
// RQ19: Deleted storage returns to the pool
// RQ20: Return in primary sequence acts as halt
// RQ21: Return in sub-sequence resumes after caller; only one return point is held, so after a nested call the outer return halts
// RQ22: Stack holds open location and count
// RQ23: Exhausted close continues at next step
`default_nettype none
module step_sequence_flow_engine import step_flow_pkg::*; (
  input wire logic i_clk,                  // 100 MHz system clock
  input wire logic i_rst_b,                // Async reset, active low
  input wire logic i_cmd_valid,            // Host command strobe
  input wire logic [2:0] i_cmd_op,         // Command code
  input wire logic [SEQ_W-1:0] i_cmd_seq,  // Sequence slot for select
  input wire logic [STEP_W-1:0] i_cmd_step,// Step position 1..21
  input wire logic [TYPE_W-1:0] i_cmd_type,// Step kind for define
  input wire logic [ARG_W-1:0] i_cmd_arg,  // Count or target slot
  input wire logic i_act_done,             // Output step finished
  output logic o_cmd_ack,                  // Command answered, pulse
  output logic o_cmd_err,                  // Command refused, with ack
  output logic [TYPE_W-1:0] o_rd_type,     // Queried step kind
  output logic [ARG_W-1:0] o_rd_arg,       // Queried parameter
  output logic o_running,                  // Sequence executing
  output logic o_paused,                   // Held at pause step
  output logic o_halted,                   // Last run ended normally
  output logic o_fault,                    // Last run ended on fault
  output logic o_act_valid,                // Output step request
  output logic [TYPE_W-1:0] o_act_type,    // Output step kind
  output logic [ARG_W-1:0] o_act_arg,      // Output step parameter
  output logic [SEQ_W-1:0] o_cur_seq,      // Executing sequence
  output logic [STEP_W-1:0] o_cur_step,    // Executing step
  output logic o_nv_erase,                 // Erase stored copy, pulse
  output logic [SEQ_W-1:0] o_nv_seq,       // Slot to erase
  output logic [SEQ_W-1:0] o_pool_free     // Free sequence slots
);
  state_t state;
  logic [SEQ_W-1:0] sel_seq;
  logic [SEQ_W-1:0] ret_seq;
  logic [STEP_W-1:0] ret_step;
  logic ret_valid;
  logic [STEP_W-1:0] clr_step;
  logic [NUM_SEQ-1:0] alloc;
  logic [WORD_W-1:0] mem_rdata;
  logic [SEQ_W-1:0] top_seq;
  logic [STEP_W-1:0] top_step;
  logic [ARG_W-1:0] top_count;
  logic stk_empty;
  logic stk_full;
  // Host command decode; edits only while idle
  wire take = i_cmd_valid && state == S_IDLE;
  wire [TYPE_W-1:0] ctype = i_cmd_type;
  wire is_def = take && i_cmd_op == CMD_DEFINE;
  wire is_query = take && i_cmd_op == CMD_QUERY;
  wire is_del = take && i_cmd_op == CMD_DEL_SEL;
  wire is_alloc = take && i_cmd_op == CMD_ALLOC_DEF;
  wire is_sel = take && i_cmd_op == CMD_SELECT;
  wire is_run = take && i_cmd_op == CMD_RUN;
  wire active = o_running || o_paused;
  wire is_stop = i_cmd_valid && i_cmd_op == CMD_STOP && active;
  wire is_resume = i_cmd_valid && i_cmd_op == CMD_RESUME && state == S_PAUSE;
  wire sel_alloc = alloc[sel_seq];
  // Step range per kind; final slot only for halt, return, jump
  wire last_ok = ctype == ST_HALT || ctype == ST_RETURN || ctype == ST_JUMP; // RQ10 RQ12 RQ14
  wire [STEP_W-1:0] max_step = last_ok ? LAST_STEP : LAST_PAUSE_STEP; // RQ16
  wire step_ok = i_cmd_step >= FIRST_STEP && i_cmd_step <= max_step;
  wire kind_ok = ctype != ST_EMPTY && ctype <= ST_POWER;
  wire names_seq = ctype == ST_JUMP || ctype == ST_SUB_ENTER;
  wire tgt_arg_ok = !names_seq || i_cmd_arg < SEQ_LIMIT; // RQ14
  wire def_ok = sel_alloc && step_ok && kind_ok && tgt_arg_ok; // RQ1
  wire qry_ok = sel_alloc && i_cmd_step >= FIRST_STEP && i_cmd_step <= LAST_STEP;
  wire seq_ok = i_cmd_seq < POOL_FULL;
  // Execution decode of the fetched step
  wire dec = state == S_DECODE;
  wire [TYPE_W-1:0] d_type = mem_rdata[WORD_W-1:ARG_W];
  wire [ARG_W-1:0] d_arg = mem_rdata[ARG_W-1:0];
  wire [SEQ_W-1:0] d_tgt = d_arg[SEQ_W-1:0];
  wire tgt_ok = d_arg < SEQ_LIMIT && alloc[d_tgt];
  wire at_end = o_cur_step == LAST_STEP;
  wire [STEP_W-1:0] step_inc = o_cur_step + STEP_W'(1);
  wire is_open = dec && d_type == ST_LOOP_OPEN;
  wire is_close = dec && d_type == ST_LOOP_CLOSE;
  wire is_out = dec && d_type >= ST_VI_MODE;
  // Loop stack control
  wire stk_push = is_open && !stk_full; // RQ4 RQ22
  wire stk_over = is_open && stk_full; // RQ4
  wire close_go = is_close && !stk_empty; // RQ7
  wire stk_pop = close_go && top_count <= ONE_PASS; // RQ23
  wire stk_dec = close_go && top_count > ONE_PASS; // RQ8
  wire stk_flush = is_run || is_stop;
  // Memory port selection; clear pass preloads halt at the last slot
  wire clr_last = clr_step == LAST_STEP;
  wire [TYPE_W-1:0] clr_type = clr_last ? ST_HALT : ST_EMPTY; // RQ11
  wire mem_we = (is_def && def_ok) || state == S_CLEAR; // RQ1
  wire [STEP_W-1:0] w_step = state == S_CLEAR ? clr_step : i_cmd_step;
  wire [ADDR_W-1:0] mem_waddr = step_addr(sel_seq, w_step);
  wire [WORD_W-1:0] def_word = {ctype, i_cmd_arg}; // RQ3
  wire [WORD_W-1:0] mem_wdata = state == S_CLEAR ? {clr_type, NO_ARG} : def_word;
  wire [ADDR_W-1:0] mem_raddr = state == S_IDLE ? step_addr(sel_seq, i_cmd_step)
                                                : step_addr(o_cur_seq, o_cur_step);
  step_store i_step_store (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );
  loop_stack i_loop_stack (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_flush(stk_flush),
    .i_push(stk_push),
    .i_pop(stk_pop),
    .i_dec(stk_dec),
    .i_seq(o_cur_seq),
    .i_step(o_cur_step),
    .i_count(d_arg),
    .o_top_seq(top_seq),
    .o_top_step(top_step),
    .o_top_count(top_count),
    .o_empty(stk_empty),
    .o_full(stk_full)
  );
  // Pool bookkeeping and stored-copy erase; one alloc or delete per cycle at most
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      alloc <= '0;
      o_pool_free <= POOL_FULL;
      o_nv_erase <= 1'b0;
      o_nv_seq <= '0;
    end else begin
      o_nv_erase <= is_del && sel_alloc; // RQ18
      o_nv_seq <= sel_seq;
      if (is_alloc && !sel_alloc) begin
        alloc[sel_seq] <= 1'b1;
        o_pool_free <= o_pool_free - POOL_STEP;
      end else if (is_del && sel_alloc) begin
        alloc[sel_seq] <= 1'b0; // RQ19
        o_pool_free <= o_pool_free + POOL_STEP; // RQ19
      end
    end
  end
  // Sequencer and host answers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= S_IDLE;
      sel_seq <= '0;
      clr_step <= FIRST_STEP;
      ret_valid <= 1'b0;
      ret_seq <= '0;
      ret_step <= FIRST_STEP;
      o_cmd_ack <= 1'b0;
      o_cmd_err <= 1'b0;
      o_rd_type <= '0;
      o_rd_arg <= '0;
      o_running <= 1'b0;
      o_paused <= 1'b0;
      o_halted <= 1'b0;
      o_fault <= 1'b0;
      o_act_valid <= 1'b0;
      o_act_type <= '0;
      o_act_arg <= '0;
      o_cur_seq <= '0;
      o_cur_step <= FIRST_STEP;
    end else begin
      o_cmd_ack <= 1'b0;
      o_cmd_err <= 1'b0;
      if (is_stop) begin
        // Stop wins over any step in flight
        state <= S_IDLE;
        o_running <= 1'b0;
        o_paused <= 1'b0;
        o_act_valid <= 1'b0;
        o_cmd_ack <= 1'b1;
      end else begin
        unique case (state)
          S_IDLE: begin
            if (take) begin
              o_cmd_ack <= !is_query && !is_alloc;
              if (is_def) begin
                o_cmd_err <= !def_ok;
              end else if (is_query) begin
                if (qry_ok) begin
                  state <= S_QUERY;
                end else begin
                  o_cmd_ack <= 1'b1;
                  o_cmd_err <= 1'b1;
                end
              end else if (is_del) begin
                o_cmd_err <= !sel_alloc;
              end else if (is_alloc) begin
                if (sel_alloc) begin
                  o_cmd_ack <= 1'b1;
                  o_cmd_err <= 1'b1;
                end else begin
                  clr_step <= FIRST_STEP;
                  state <= S_CLEAR;
                end
              end else if (is_sel) begin
                o_cmd_err <= !seq_ok;
                if (seq_ok) begin
                  sel_seq <= i_cmd_seq;
                end
              end else if (is_run) begin
                o_cmd_err <= !sel_alloc;
                if (sel_alloc) begin
                  o_cur_seq <= sel_seq;
                  o_cur_step <= FIRST_STEP;
                  ret_valid <= 1'b0;
                  o_running <= 1'b1;
                  o_halted <= 1'b0;
                  o_fault <= 1'b0;
                  state <= S_FETCH;
                end
              end else begin
                o_cmd_err <= 1'b1;
              end
            end
          end
          S_CLEAR: begin
            clr_step <= clr_step + STEP_W'(1);
            if (clr_last) begin
              o_cmd_ack <= 1'b1;
              state <= S_IDLE;
            end
          end
          S_QUERY: begin
            o_rd_type <= d_type; // RQ17
            o_rd_arg <= d_arg; // RQ17
            o_cmd_ack <= 1'b1;
            state <= S_IDLE;
          end
          S_FETCH: begin
            state <= S_DECODE;
          end
          S_DECODE: begin
            state <= S_FETCH;
            if (stk_over || (is_close && stk_empty)) begin
              o_running <= 1'b0;
              o_fault <= 1'b1;
              state <= S_IDLE;
            end else if (stk_dec) begin
              o_cur_seq <= top_seq; // RQ5 RQ8
              o_cur_step <= top_step + STEP_W'(1); // RQ2 RQ8
            end else if (d_type == ST_JUMP || d_type == ST_SUB_ENTER) begin
              if (tgt_ok) begin
                o_cur_seq <= d_tgt; // RQ13
                o_cur_step <= FIRST_STEP; // RQ13
                if (d_type == ST_SUB_ENTER) begin
                  ret_valid <= 1'b1;
                  ret_seq <= o_cur_seq;
                  ret_step <= step_inc;
                end
              end else begin
                o_running <= 1'b0;
                o_fault <= 1'b1;
                state <= S_IDLE;
              end
            end else if (d_type == ST_RETURN && ret_valid) begin
              ret_valid <= 1'b0;
              o_cur_seq <= ret_seq; // RQ21
              o_cur_step <= ret_step; // RQ21
            end else if (d_type == ST_HALT || d_type == ST_RETURN || d_type == ST_EMPTY) begin
              // Output requests stay as last issued, so the supply holds its state
              o_running <= 1'b0; // RQ9 RQ20
              o_halted <= 1'b1; // RQ9 RQ20
              state <= S_IDLE;
            end else if (is_out) begin
              o_act_valid <= 1'b1;
              o_act_type <= d_type;
              o_act_arg <= d_arg;
              state <= S_ACT;
            end else if (at_end) begin
              o_running <= 1'b0;
              o_halted <= 1'b1;
              state <= S_IDLE;
            end else begin
              o_cur_step <= step_inc; // RQ23
              if (d_type == ST_PAUSE) begin
                o_running <= 1'b0; // RQ15
                o_paused <= 1'b1; // RQ15
                state <= S_PAUSE;
              end
            end
          end
          S_ACT: begin
            if (i_act_done) begin
              o_act_valid <= 1'b0;
              state <= S_FETCH;
              o_cur_step <= step_inc;
              if (at_end) begin
                o_running <= 1'b0;
                o_halted <= 1'b1;
                state <= S_IDLE;
              end
            end
          end
          S_PAUSE: begin
            if (is_resume) begin
              o_paused <= 1'b0; // RQ15
              o_running <= 1'b1;
              o_cmd_ack <= 1'b1;
              state <= S_FETCH;
            end
          end
        endcase
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_define_store; is_def && def_ok |=> o_cmd_ack && !o_cmd_err; endproperty
  a_define_store: assert property (p_define_store) else $error("define not accepted"); // RQ1
  property p_pause_slot; is_def && ctype == ST_PAUSE && i_cmd_step == LAST_STEP |=> o_cmd_ack && o_cmd_err; endproperty
  a_pause_slot: assert property (p_pause_slot) else $error("pause at last step taken"); // RQ16
  property p_halt_hold;
    dec && d_type == ST_HALT && !is_stop |=> o_halted && !o_running && $stable(o_act_type);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt did not end run"); // RQ9
  property p_jump_target;
    dec && d_type == ST_JUMP && tgt_ok && !is_stop
      |=> o_cur_seq == $past(d_tgt) && o_cur_step == FIRST_STEP ##1 state == S_DECODE;
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump went astray"); // RQ13
  property p_close_back;
    stk_dec && !is_stop |=> o_cur_step == $past(top_step) + STEP_W'(1) && o_cur_seq == $past(top_seq);
  endproperty
  a_close_back: assert property (p_close_back) else $error("close did not loop back"); // RQ8
  property p_close_exit; stk_pop && !is_stop |=> o_cur_step == $past(o_cur_step) + STEP_W'(1); endproperty
  a_close_exit: assert property (p_close_exit) else $error("exhausted close misplaced"); // RQ23
  property p_nest_limit; stk_over && !is_stop |=> o_fault && state == S_IDLE; endproperty
  a_nest_limit: assert property (p_nest_limit) else $error("nesting overflow missed"); // RQ4
  property p_return_primary;
    dec && d_type == ST_RETURN && !ret_valid && !is_stop |=> o_halted && !o_running;
  endproperty
  a_return_primary: assert property (p_return_primary) else $error("return did not halt"); // RQ20
  property p_pause_wait; o_paused && !i_cmd_valid |=> o_paused && !o_running; endproperty
  a_pause_wait: assert property (p_pause_wait) else $error("pause left without resume"); // RQ15
  property p_alloc_halt; state == S_CLEAR && clr_last |-> mem_we && mem_wdata[WORD_W-1:ARG_W] == ST_HALT; endproperty
  a_alloc_halt: assert property (p_alloc_halt) else $error("final halt not preloaded"); // RQ11
  property p_delete_pool;
    is_del && sel_alloc |=> o_nv_erase && !alloc[$past(sel_seq)] && o_pool_free == $past(o_pool_free) + POOL_STEP;
  endproperty
  a_delete_pool: assert property (p_delete_pool) else $error("delete did not free slot"); // RQ18 RQ19
  c_loop_back: cover property (stk_dec ##[1:40] stk_pop);
  c_pause_resume: cover property (o_paused ##[1:20] is_resume);
  c_sub_return: cover property (dec && d_type == ST_RETURN && ret_valid);
  c_delete: cover property (is_del && sel_alloc);
endmodule // step_sequence_flow_engine
`default_nettype wire

/* hw/step_flow_pkg.sv */
// Shared constants and types for the stored-step flow engine
`default_nettype none
package step_flow_pkg;
  localparam int NUM_SEQ = 50;
  localparam int NUM_STEP = 21;
  localparam int LOOP_DEPTH = 10;
  localparam int SEQ_W = 6;
  localparam int STEP_W = 5;
  localparam int TYPE_W = 4;
  localparam int ARG_W = 16;
  localparam int ADDR_W = 11;
  localparam int PTR_W = 4;
  localparam int WORD_W = TYPE_W + ARG_W;
  localparam int MEM_DEPTH = NUM_SEQ * NUM_STEP;
  localparam logic [STEP_W-1:0] FIRST_STEP = 5'h01;
  localparam logic [STEP_W-1:0] LAST_STEP = 5'h15;
  localparam logic [STEP_W-1:0] LAST_PAUSE_STEP = 5'h14;
  localparam logic [ARG_W-1:0] ONE_PASS = 16'h0001;
  localparam logic [ARG_W-1:0] NO_ARG = 16'h0000;
  localparam logic [ARG_W-1:0] SEQ_LIMIT = 16'h0032;
  localparam logic [SEQ_W-1:0] POOL_FULL = 6'h32;
  localparam logic [SEQ_W-1:0] POOL_STEP = 6'h01;

  // Step kinds held in the step memory
  typedef enum logic [TYPE_W-1:0] {
    ST_EMPTY = 4'h0, ST_LOOP_OPEN = 4'h1, ST_LOOP_CLOSE = 4'h2, ST_HALT = 4'h3,
    ST_JUMP = 4'h4, ST_PAUSE = 4'h5, ST_RETURN = 4'h6, ST_SUB_ENTER = 4'h7,
    ST_VI_MODE = 4'h8, ST_RAMP_V = 4'h9, ST_RAMP_C = 4'hA, ST_POWER = 4'hB
  } step_type_t;

  // Host commands
  typedef enum logic [2:0] {
    CMD_DEFINE = 3'h0, CMD_QUERY = 3'h1, CMD_DEL_SEL = 3'h2, CMD_ALLOC_DEF = 3'h3,
    CMD_SELECT = 3'h4, CMD_RUN = 3'h5, CMD_RESUME = 3'h6, CMD_STOP = 3'h7
  } cmd_t;

  // Engine states, Gray along idle-fetch-decode-act
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_FETCH = 3'h1, S_DECODE = 3'h3, S_ACT = 3'h2,
    S_PAUSE = 3'h6, S_CLEAR = 3'h7, S_QUERY = 3'h5
  } state_t;

  // Flat step-memory address of a sequence slot and 1-based step
  function automatic logic [ADDR_W-1:0] step_addr(input logic [SEQ_W-1:0] seq,
                                                  input logic [STEP_W-1:0] step);
    step_addr = ADDR_W'(seq) * ADDR_W'(NUM_STEP) + ADDR_W'(step) - ADDR_W'(FIRST_STEP);
  endfunction
endpackage
`default_nettype wire

/* hw/step_store.sv */
// Step memory: one write port, one registered read port
`default_nettype none
module step_store import step_flow_pkg::*; (
  input wire logic i_clk,                  // System clock
  input wire logic i_we,                   // Write strobe
  input wire logic [ADDR_W-1:0] i_waddr,   // Write address
  input wire logic [WORD_W-1:0] i_wdata,   // Write word
  input wire logic [ADDR_W-1:0] i_raddr,   // Read address
  output logic [WORD_W-1:0] o_rdata        // Read word, one cycle later
);
  logic [WORD_W-1:0] mem [MEM_DEPTH];

  // No reset on the array so it maps to block memory
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // step_store
`default_nettype wire

/* hw/loop_stack.sv */
// Loop stack: open location and remaining count per active loop
`default_nettype none
module loop_stack import step_flow_pkg::*; (
  input wire logic i_clk,                  // System clock
  input wire logic i_rst_b,                // Async reset, active low
  input wire logic i_flush,                // Drop all entries
  input wire logic i_push,                 // Push new loop
  input wire logic i_pop,                  // Pop exhausted loop
  input wire logic i_dec,                  // Decrement top count
  input wire logic [SEQ_W-1:0] i_seq,      // Loop-open sequence
  input wire logic [STEP_W-1:0] i_step,    // Loop-open step
  input wire logic [ARG_W-1:0] i_count,    // Loop count
  output logic [SEQ_W-1:0] o_top_seq,      // Top entry sequence
  output logic [STEP_W-1:0] o_top_step,    // Top entry step
  output logic [ARG_W-1:0] o_top_count,    // Top remaining count
  output logic o_empty,                    // No active loop
  output logic o_full                      // Depth reached
);
  logic [SEQ_W-1:0] seq_q [LOOP_DEPTH];
  logic [STEP_W-1:0] step_q [LOOP_DEPTH];
  logic [ARG_W-1:0] cnt_q [LOOP_DEPTH];
  logic [PTR_W-1:0] depth;
  wire [PTR_W-1:0] top = depth - PTR_W'(1);

  assign o_empty = depth == '0;
  assign o_full = depth == PTR_W'(LOOP_DEPTH);
  assign o_top_seq = o_empty ? '0 : seq_q[top];
  assign o_top_step = o_empty ? '0 : step_q[top];
  assign o_top_count = o_empty ? '0 : cnt_q[top];

  // Depth pointer; caller never pushes when full
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      depth <= '0;
    end else if (i_flush) begin
      depth <= '0;
    end else if (i_push) begin
      depth <= depth + PTR_W'(1);
    end else if (i_pop) begin
      depth <= top;
    end
  end

  // Entry storage
  always_ff @(posedge i_clk) begin
    if (i_push) begin
      seq_q[depth] <= i_seq;
      step_q[depth] <= i_step;
      cnt_q[depth] <= i_count;
    end else if (i_dec) begin
      cnt_q[top] <= cnt_q[top] - ONE_PASS;
    end
  end
endmodule // loop_stack
`default_nettype wire

/* tb/out_stage_model.sv */
// Output-stage model that finishes each requested output step
`default_nettype none
module out_stage_model (
  input wire logic i_clk,       // System clock
  input wire logic i_rst_b,     // Reset, active low
  input wire logic i_act_valid, // Output step request
  output logic o_act_done       // Output step finished
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_cnt;
  logic slow;
  // Alternate prompt and slow answers so the request must be held
  always @(negedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt <= 3'h0;
      slow <= 1'b0;
      o_act_done <= 1'b0;
    end else if (o_act_done) begin
      o_act_done <= 1'b0;
      wait_cnt <= 3'h0;
      slow <= ~slow;
    end else if (i_act_valid) begin
      if (wait_cnt == (slow ? 3'h4 : 3'h0)) o_act_done <= 1'b1;
      else wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule // out_stage_model
`default_nettype wire

/* tb/step_sequence_flow_engine_tb_top.sv */
// Self-checking bench for the step flow engine
`default_nettype none
module step_sequence_flow_engine_tb_top import step_flow_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_cmd_valid = 1'b0, i_act_done, act_q = 1'b0;
  logic [2:0] i_cmd_op = 3'h0;
  logic [SEQ_W-1:0] i_cmd_seq = 6'h00;
  logic [STEP_W-1:0] i_cmd_step = 5'h01;
  logic [TYPE_W-1:0] i_cmd_type = 4'h0;
  logic [ARG_W-1:0] i_cmd_arg = 16'h0000;
  logic o_cmd_ack, o_cmd_err, o_running, o_paused, o_halted, o_fault, o_act_valid, o_nv_erase;
  logic [TYPE_W-1:0] o_rd_type, o_act_type;
  logic [ARG_W-1:0] o_rd_arg, o_act_arg;
  logic [SEQ_W-1:0] o_cur_seq, o_nv_seq, o_pool_free;
  logic [STEP_W-1:0] o_cur_step;
  int n_mismatch = 0, comparisons = 0, n_act = 0, k;
  step_sequence_flow_engine i_step_sequence_flow_engine (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_seq(i_cmd_seq), .i_cmd_step(i_cmd_step),
    .i_cmd_type(i_cmd_type), .i_cmd_arg(i_cmd_arg), .i_act_done(i_act_done), .o_cmd_ack(o_cmd_ack),
    .o_cmd_err(o_cmd_err), .o_rd_type(o_rd_type), .o_rd_arg(o_rd_arg), .o_running(o_running),
    .o_paused(o_paused), .o_halted(o_halted), .o_fault(o_fault), .o_act_valid(o_act_valid),
    .o_act_type(o_act_type), .o_act_arg(o_act_arg), .o_cur_seq(o_cur_seq), .o_cur_step(o_cur_step),
    .o_nv_erase(o_nv_erase), .o_nv_seq(o_nv_seq), .o_pool_free(o_pool_free));
  out_stage_model i_out_stage_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_act_valid(o_act_valid),
    .o_act_done(i_act_done));
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  // Count output steps started
  always @(negedge i_clk) begin
    act_q <= o_act_valid;
    if (o_act_valid === 1'b1 && act_q === 1'b0) n_act++;
  end
  task automatic check(input logic [ARG_W-1:0] seen, input logic [ARG_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stuck;
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    test_done();
  endtask
  // One command, held one cycle, then wait for its answer
  task automatic cmd(input logic [2:0] op, input logic [SEQ_W-1:0] seq, input logic [STEP_W-1:0] step,
                     input logic [TYPE_W-1:0] typ, input logic [ARG_W-1:0] arg, input logic exp_err);
    int i;
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd_op = op;
    i_cmd_seq = seq;
    i_cmd_step = step;
    i_cmd_type = typ;
    i_cmd_arg = arg;
    for (i = 0; i < 40; i++) begin
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      if (o_cmd_ack === 1'b1) break;
    end
    if (i == 40) stuck();
    check(16'(o_cmd_err), 16'(exp_err));
  endtask
  // Bounded wait for pause or for a finished run
  task automatic wait_state(input bit want_halt);
    int i;
    for (i = 0; i < 8000; i++) begin
      @(negedge i_clk);
      if (want_halt ? (o_halted === 1'b1 && o_running === 1'b0) : o_paused === 1'b1) break;
    end
    if (i == 8000) stuck();
  endtask
  task automatic t_alloc;
    check(16'(o_pool_free), 16'h0032);
    check(16'(o_cur_step), 16'h0001);
    for (k = 1; k >= 0; k--) begin
      cmd(CMD_SELECT, 6'(k), 5'h01, ST_EMPTY, 16'h0000, 1'b0);
      cmd(CMD_ALLOC_DEF, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    end
    check(16'(o_pool_free), 16'h0030);
    cmd(CMD_QUERY, 6'h00, 5'h15, ST_EMPTY, 16'h0000, 1'b0);
    check(16'(o_rd_type), 16'(ST_HALT));
  endtask
  task automatic t_limits;
    cmd(CMD_DEFINE, 6'h00, 5'h15, ST_PAUSE, 16'h0000, 1'b1);
    cmd(CMD_DEFINE, 6'h00, 5'h14, ST_PAUSE, 16'h0000, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h15, ST_JUMP, 16'h0001, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h15, ST_HALT, 16'h0000, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h01, ST_LOOP_OPEN, 16'hFFFF, 1'b0);
    cmd(CMD_QUERY, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    check(o_rd_arg, 16'hFFFF);
  endtask
  // Loop of three around one output step, pause, then jump to slot 1
  task automatic t_loop_pause_jump;
    cmd(CMD_DEFINE, 6'h00, 5'h01, ST_LOOP_OPEN, 16'h0003, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h02, ST_VI_MODE, 16'h1234, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h03, ST_LOOP_CLOSE, 16'h0000, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h04, ST_PAUSE, 16'h0000, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h05, ST_JUMP, 16'h0001, 1'b0);
    cmd(CMD_DEFINE, 6'h01, 5'h01, ST_EMPTY, 16'h0000, 1'b1);
    cmd(CMD_QUERY, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    check({o_rd_type, o_rd_arg[11:0]}, {ST_LOOP_OPEN, 12'h003});
    cmd(CMD_RUN, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    wait_state(1'b0);
    check(16'(n_act), 16'h0003);
    check(16'(o_cur_step), 16'h0005);
    repeat (5) @(negedge i_clk);
    check(16'(o_paused), 16'h0001);
    cmd(CMD_RESUME, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    wait_state(1'b1);
    check(16'(o_cur_seq), 16'h0001);
    check(16'(n_act), 16'h0003);
    check(o_act_arg, 16'h1234);
    check(16'(o_act_type), 16'(ST_VI_MODE));
  endtask
  // Ten nested loops fill steps 1 to 20 with halt left at 21
  task automatic t_nest;
    for (k = 1; k <= 20; k++)
      cmd(CMD_DEFINE, 6'h00, 5'(k), (k <= 10) ? ST_LOOP_OPEN : ST_LOOP_CLOSE, 16'h0002, 1'b0);
    cmd(CMD_RUN, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    wait_state(1'b1);
    check(16'(o_fault), 16'h0000);
  endtask
  // Loop opened in slot 0 closes in sub-entered slot 1; returns then halt
  task automatic t_span;
    int n0 = n_act;
    cmd(CMD_SELECT, 6'h01, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h01, ST_LOOP_CLOSE, 16'h0000, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h02, ST_RETURN, 16'h0000, 1'b0);
    cmd(CMD_SELECT, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h01, ST_LOOP_OPEN, 16'h0002, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h02, ST_VI_MODE, 16'h0042, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h03, ST_SUB_ENTER, 16'h0001, 1'b0);
    cmd(CMD_DEFINE, 6'h00, 5'h04, ST_RETURN, 16'h0000, 1'b0);
    cmd(CMD_RUN, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    wait_state(1'b1);
    check(16'(n_act - n0), 16'h0002);
    check({o_fault, 4'h0, o_cur_step, o_cur_seq}, {1'b0, 4'h0, 5'h04, 6'h00});
  endtask
  task automatic t_delete;
    cmd(CMD_SELECT, 6'h01, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    cmd(CMD_DEL_SEL, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b0);
    check({o_nv_erase, 9'h000, o_nv_seq}, 16'h8001);
    @(negedge i_clk);
    check(16'(o_pool_free), 16'h0031);
    cmd(CMD_QUERY, 6'h00, 5'h01, ST_EMPTY, 16'h0000, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_b = 1'b1;
    t_alloc();
    t_limits();
    t_loop_pause_jump();
    t_nest();
    t_span();
    t_delete();
    test_done();
  end
endmodule // step_sequence_flow_engine_tb_top
`default_nettype wire
